// *** core/uswl_pkg.sv ***
package uswl_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_USB_CFG_A    = 8'h00;
  localparam logic [7:0] OFF_USB_CFG_B    = 8'h04;
  localparam logic [7:0] OFF_PM_CTL       = 8'h08;
  localparam logic [7:0] OFF_IDLE_LAT_A   = 8'h0c;
  localparam logic [7:0] OFF_IDLE_LAT_B   = 8'h10;
  localparam logic [7:0] OFF_ACT_LAT_A    = 8'h14;
  localparam logic [7:0] OFF_ACT_LAT_B    = 8'h18;
  localparam logic [7:0] OFF_INACT_A      = 8'h1c;
  localparam logic [7:0] OFF_INACT_B      = 8'h20;
  localparam logic [7:0] OFF_STATUS       = 8'h24;
  // usb_config_reg_a fields
  localparam int BIT_REMOTE_WAKE_SUPPORT  = 0;
  localparam int BIT_LINK_PM_CAPABILITY   = 1;
  // usb_config_reg_b fields
  localparam int BIT_LTM_CFG_ENABLE       = 0;
  // power_mgmt_control_reg fields
  localparam int POS_SUSPEND_LEVEL        = 0;
  localparam int WID_SUSPEND_LEVEL        = 2;
  // latency and reload fields
  localparam int WID_BELT                 = 12;
  localparam int WID_RELOAD               = 16;
  // reset values, and the u2_timeout code for self-initiated U2 entry
  localparam logic [31:0] RST_USB_CFG_A   = 32'h0000_0003;
  localparam logic [31:0] RST_USB_CFG_B   = 32'h0000_0000;
  localparam logic [31:0] RST_PM_CTL      = 32'h0000_0000;
  localparam logic [31:0] RST_LATENCY     = 32'h0000_0000;
  localparam logic [31:0] RST_INACT       = 32'h0000_0000;
  localparam logic [7:0]  U2_TIMEOUT_SELF = 8'hff;
  // timing
  localparam int CLK_PERIOD_NS            = 10;
  localparam int U2_IDLE_MS               = 10;
  localparam int WAKE_RETRY_MS            = 2500;
  localparam int U2_IDLE_CYCLES  = U2_IDLE_MS * (1000000 / CLK_PERIOD_NS);
  localparam int WAKE_RETRY_CYCLES = WAKE_RETRY_MS * (1000000 / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    USWL_SPD_NONE = 2'b00,
    USWL_SPD_GIG  = 2'b01,
    USWL_SPD_FAST = 2'b10,
    USWL_SPD_SLOW = 2'b11
  } uswl_eth_speed_e;

  typedef enum logic [1:0] {
    USWL_LNK_U0 = 2'b00,
    USWL_LNK_U1 = 2'b01,
    USWL_LNK_U2 = 2'b10,
    USWL_LNK_U3 = 2'b11
  } uswl_link_state_e;

  typedef enum logic [1:0] {
    USWL_WK_IDLE = 2'b00,
    USWL_WK_WAIT = 2'b01,
    USWL_WK_SENT = 2'b10
  } uswl_wake_e;

  // host requests as seen from the device controller
  typedef struct packed {
    logic super_speed;
    logic func_suspend;
    logic func_rwake_en;
    logic dev_rwake_en;
    logic ltm_feature;
    logic host_access;
    logic pkt_pending;
    logic [7:0] u2_timeout;
  } uswl_host_s;

  // internal traffic indications
  typedef struct packed {
    logic bulk_in_empty;
    logic bulk_out_empty;
    logic eth_tx_empty;
    logic eth_rx_empty;
    logic ep_pkt_pending;
    logic eth_frame_rx;
    logic eth_frame_pass;
    logic wake_event;
  } uswl_traffic_s;

  typedef struct packed {
    logic [WID_SUSPEND_LEVEL-1:0] level;
    logic                         apply;
  } uswl_power_s;
endpackage : uswl_pkg

// *** core/uswl_ctrl.sv ***
// Functional notes
// - function suspend honoured only at SuperSpeed
// - suspended in Ux: apply selected power savings
// - remote wake needs suspend option enabled
// - SuperSpeed ignores device remote wakeup selector
// - suspended, timeout 0xFF: U2 after 10 ms
// - wake event in Ux starts U0 transition
// - in U0 after wake send notification
// - resend notification after 2500 ms silence
// - HS/FS wake needs host enable plus support
// - latency messaging enabled by configuration bit
// - idle entry needs all FIFOs empty
// - counter expiry sends idle latency message
// - any FIFO non-empty moves to active
// - reset idle; idle without ethernet link
// - latency chosen per speed, gig default
// - messaging only after host feature enable
// - frame or pending packets: active, U0
// - traffic stop loads reload down-counter
// - new traffic stops counter at once
// - link pm only with capability bit
// - L1 exits on filtered received frame
// - L2 applies suspend power level savings
`timescale 1ns/100ps
`default_nettype none
module uswl_ctrl #(
  parameter int U2_IDLE_CYC    = uswl_pkg::U2_IDLE_CYCLES,
  parameter int WAKE_RETRY_CYC = uswl_pkg::WAKE_RETRY_CYCLES
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire uswl_pkg::uswl_host_s      host,
  input  wire uswl_pkg::uswl_traffic_s   traffic,
  input  wire uswl_pkg::uswl_link_state_e link_state,
  input  wire logic                      link_l1,
  input  wire logic                      link_l2,
  input  wire uswl_pkg::uswl_eth_speed_e eth_speed,
  output uswl_pkg::uswl_power_s          power,
  output logic                           req_u0,
  output logic                           req_u2,
  output logic                           req_l0,
  output logic                           func_wake_notify,
  output logic                           hs_resume,
  output logic                           ltm_send,
  output logic [uswl_pkg::WID_BELT-1:0]  ltm_belt,
  output logic                           lpm_enable
);
  localparam int WB = uswl_pkg::WID_BELT;
  localparam int WR = uswl_pkg::WID_RELOAD;

  logic [31:0] usb_config_reg_a;
  logic [31:0] usb_config_reg_b;
  logic [31:0] power_mgmt_control_reg;
  logic [31:0] idle_lat_a;
  logic [31:0] idle_lat_b;
  logic [31:0] act_lat_a;
  logic [31:0] act_lat_b;
  logic [31:0] inact_a;
  logic [31:0] inact_b;

  logic            aw_held;
  logic            w_held;
  logic [7:0]      aw_addr;
  logic [31:0]     w_data;
  logic [3:0]      w_strb;
  logic            ltm_active;
  logic [WR-1:0]   inact_cnt;
  logic            inact_run;
  logic [31:0]     u2_cnt;
  logic [31:0]     retry_cnt;
  uswl_pkg::uswl_wake_e wake_st;

  logic remote_wake_support_bit;
  logic link_pm_capability_bit;
  logic ltm_cfg_en;
  assign remote_wake_support_bit = usb_config_reg_a[uswl_pkg::BIT_REMOTE_WAKE_SUPPORT];
  assign link_pm_capability_bit  = usb_config_reg_a[uswl_pkg::BIT_LINK_PM_CAPABILITY];
  assign ltm_cfg_en              = usb_config_reg_b[uswl_pkg::BIT_LTM_CFG_ENABLE];

  // host and traffic come from logic on aclk, so no synchronisers
  logic fs_active;
  logic in_ux;
  logic all_empty;
  logic traffic_now;
  logic wake_ok;
  assign fs_active   = host.super_speed & host.func_suspend;
  assign in_ux       = link_state != uswl_pkg::USWL_LNK_U0;
  assign all_empty   = traffic.bulk_in_empty & traffic.bulk_out_empty &
                       traffic.eth_tx_empty & traffic.eth_rx_empty &
                       ~traffic.ep_pkt_pending & ~host.pkt_pending;
  assign traffic_now = ~all_empty | traffic.eth_frame_rx;
  // SuperSpeed consults only the suspend option
  assign wake_ok     = remote_wake_support_bit &
                       (host.super_speed ? (fs_active & host.func_rwake_en)
                                         : host.dev_rwake_en);

  // per-speed latency and reload selection
  logic [WB-1:0] idle_sel;
  logic [WB-1:0] act_sel;
  logic [WR-1:0] reload_sel;
  always_comb begin
    unique case (eth_speed)
      uswl_pkg::USWL_SPD_FAST: begin
        idle_sel   = idle_lat_a[16 +: WB];
        act_sel    = act_lat_a[16 +: WB];
        reload_sel = inact_a[16 +: WR];
      end
      uswl_pkg::USWL_SPD_SLOW: begin
        idle_sel   = idle_lat_b[0 +: WB];
        act_sel    = act_lat_b[0 +: WB];
        reload_sel = inact_b[0 +: WR];
      end
      default: begin
        idle_sel   = idle_lat_a[0 +: WB];
        act_sel    = act_lat_a[0 +: WB];
        reload_sel = inact_a[0 +: WR];
      end
    endcase
  end

  // AXI4-Lite write: address and data accepted in either order
  logic wr_go;
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[7:2] <= uswl_pkg::OFF_INACT_B[7:2]) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_config_reg_a       <= uswl_pkg::RST_USB_CFG_A;
      usb_config_reg_b       <= uswl_pkg::RST_USB_CFG_B;
      power_mgmt_control_reg <= uswl_pkg::RST_PM_CTL;
      idle_lat_a             <= uswl_pkg::RST_LATENCY;
      idle_lat_b             <= uswl_pkg::RST_LATENCY;
      act_lat_a              <= uswl_pkg::RST_LATENCY;
      act_lat_b              <= uswl_pkg::RST_LATENCY;
      inact_a                <= uswl_pkg::RST_INACT;
      inact_b                <= uswl_pkg::RST_INACT;
    end else if (wr_go) begin
      unique case (aw_addr)
        uswl_pkg::OFF_USB_CFG_A:  usb_config_reg_a <= merge(usb_config_reg_a, w_data, w_strb);
        uswl_pkg::OFF_USB_CFG_B:  usb_config_reg_b <= merge(usb_config_reg_b, w_data, w_strb);
        uswl_pkg::OFF_PM_CTL:
          power_mgmt_control_reg <= merge(power_mgmt_control_reg, w_data, w_strb);
        uswl_pkg::OFF_IDLE_LAT_A: idle_lat_a <= merge(idle_lat_a, w_data, w_strb);
        uswl_pkg::OFF_IDLE_LAT_B: idle_lat_b <= merge(idle_lat_b, w_data, w_strb);
        uswl_pkg::OFF_ACT_LAT_A:  act_lat_a  <= merge(act_lat_a, w_data, w_strb);
        uswl_pkg::OFF_ACT_LAT_B:  act_lat_b  <= merge(act_lat_b, w_data, w_strb);
        uswl_pkg::OFF_INACT_A:    inact_a    <= merge(inact_a, w_data, w_strb);
        uswl_pkg::OFF_INACT_B:    inact_b    <= merge(inact_b, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // AXI4-Lite read, one cycle after the address is taken
  logic [31:0] rd_mux;
  always_comb begin
    unique case (s_axi_araddr)
      uswl_pkg::OFF_USB_CFG_A:  rd_mux = usb_config_reg_a;
      uswl_pkg::OFF_USB_CFG_B:  rd_mux = usb_config_reg_b;
      uswl_pkg::OFF_PM_CTL:     rd_mux = power_mgmt_control_reg;
      uswl_pkg::OFF_IDLE_LAT_A: rd_mux = idle_lat_a;
      uswl_pkg::OFF_IDLE_LAT_B: rd_mux = idle_lat_b;
      uswl_pkg::OFF_ACT_LAT_A:  rd_mux = act_lat_a;
      uswl_pkg::OFF_ACT_LAT_B:  rd_mux = act_lat_b;
      uswl_pkg::OFF_INACT_A:    rd_mux = inact_a;
      uswl_pkg::OFF_INACT_B:    rd_mux = inact_b;
      uswl_pkg::OFF_STATUS:
        rd_mux = {26'h000_0000, lpm_enable, ltm_send, wake_st, inact_run, ltm_active};
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= (s_axi_araddr[7:2] <= uswl_pkg::OFF_STATUS[7:2]) ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // latency messaging state and inactivity down-counter
  logic ltm_on;
  assign ltm_on = ltm_cfg_en & host.ltm_feature;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ltm_active <= 1'b0;
      inact_run  <= 1'b0;
      inact_cnt  <= '0;
      ltm_send   <= 1'b0;
      ltm_belt   <= '0;
    end else begin
      ltm_send <= 1'b0;
      if (eth_speed == uswl_pkg::USWL_SPD_NONE) begin
        ltm_active <= 1'b0;
        inact_run  <= 1'b0;
      end else if (traffic_now) begin
        inact_run <= 1'b0;
        if (!ltm_active) begin
          ltm_active <= 1'b1;
          ltm_send   <= ltm_on;
          ltm_belt   <= act_sel;
        end
      end else if (ltm_active && !inact_run) begin
        inact_run <= 1'b1;
        inact_cnt <= reload_sel;
      end else if (inact_run) begin
        if (inact_cnt == '0) begin
          inact_run  <= 1'b0;
          ltm_active <= 1'b0;
          ltm_send   <= ltm_on;
          ltm_belt   <= idle_sel;
        end else begin
          inact_cnt <= inact_cnt - 1'b1;
        end
      end
    end
  end

  // function remote wake sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_st          <= uswl_pkg::USWL_WK_IDLE;
      retry_cnt        <= 32'h0000_0000;
      func_wake_notify <= 1'b0;
      hs_resume        <= 1'b0;
    end else begin
      func_wake_notify <= 1'b0;
      hs_resume        <= 1'b0;
      unique case (wake_st)
        uswl_pkg::USWL_WK_IDLE: begin
          if (traffic.wake_event && wake_ok) begin
            if (host.super_speed) wake_st <= uswl_pkg::USWL_WK_WAIT;
            else hs_resume <= 1'b1;
          end
        end
        uswl_pkg::USWL_WK_WAIT: begin
          if (!in_ux) begin
            func_wake_notify <= 1'b1;
            retry_cnt        <= 32'h0000_0000;
            wake_st          <= uswl_pkg::USWL_WK_SENT;
          end
        end
        uswl_pkg::USWL_WK_SENT: begin
          // host access or option cleared ends the sequence
          if (host.host_access || !host.func_rwake_en) begin
            wake_st <= uswl_pkg::USWL_WK_IDLE;
          end else if (retry_cnt == WAKE_RETRY_CYC - 1) begin
            wake_st <= uswl_pkg::USWL_WK_WAIT;
          end else begin
            retry_cnt <= retry_cnt + 32'h0000_0001;
          end
        end
        default: wake_st <= uswl_pkg::USWL_WK_IDLE;
      endcase
    end
  end

  // link requests and power level
  logic pm_on;
  assign pm_on = link_pm_capability_bit & ~host.super_speed;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      u2_cnt     <= 32'h0000_0000;
      req_u2     <= 1'b0;
      req_u0     <= 1'b0;
      req_l0     <= 1'b0;
      lpm_enable <= 1'b0;
      power      <= '0;
    end else begin
      lpm_enable <= pm_on;
      req_u0 <= in_ux & host.super_speed & ((wake_st == uswl_pkg::USWL_WK_WAIT)
                | (traffic_now & ~all_empty) | host.pkt_pending | traffic.eth_frame_rx);
      req_l0 <= pm_on & link_l1 & traffic.eth_frame_pass;
      // link inactivity while function suspended
      if (fs_active && host.u2_timeout == uswl_pkg::U2_TIMEOUT_SELF
          && link_state == uswl_pkg::USWL_LNK_U1 && all_empty) begin
        if (u2_cnt == U2_IDLE_CYC - 1) req_u2 <= 1'b1;
        else u2_cnt <= u2_cnt + 32'h0000_0001;
      end else begin
        u2_cnt <= 32'h0000_0000;
        req_u2 <= 1'b0;
      end
      power.level <= power_mgmt_control_reg[uswl_pkg::POS_SUSPEND_LEVEL +: uswl_pkg::WID_SUSPEND_LEVEL];
      power.apply <= (fs_active & in_ux) | (pm_on & link_l2);
    end
  end
endmodule : uswl_ctrl
`default_nettype wire

// *** tb/uswl_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module uswl_host_model #(
  parameter int DLY = 3
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       req_u0,
  input  wire logic                       req_u2,
  input  wire logic                       req_l0,
  input  wire logic                       go,
  input  wire uswl_pkg::uswl_link_state_e go_state,
  input  wire logic                       go_l1,
  input  wire logic                       arm,
  input  wire logic                       ack,
  output uswl_pkg::uswl_link_state_e      link_state,
  output logic                            link_l1,
  output logic                            func_rwake_en,
  output logic                            host_access
);
  logic [3:0] wait_cnt;
  // exits are granted late on purpose, as a busy host would
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_state <= uswl_pkg::USWL_LNK_U0;
      link_l1    <= 1'h0;
      wait_cnt   <= 4'h0;
    end else if (go) begin
      link_state <= go_state;
      link_l1    <= go_l1;
    end else if ((req_u0 && link_state != uswl_pkg::USWL_LNK_U0) || (req_l0 && link_l1)) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt == 4'(DLY)) begin
        link_state <= uswl_pkg::USWL_LNK_U0;
        link_l1    <= 1'h0;
        wait_cnt   <= 4'h0;
      end
    end else if (req_u2 && link_state == uswl_pkg::USWL_LNK_U1) begin
      link_state <= uswl_pkg::USWL_LNK_U2;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_rwake_en <= 1'h0;
      host_access   <= 1'h0;
    end else begin
      host_access <= ack;
      if (arm) begin
        func_rwake_en <= 1'h1;
      end else if (ack) begin
        func_rwake_en <= 1'h0;
      end
    end
  end
endmodule : uswl_host_model
`default_nettype wire

// *** tb/uswl_ctrl_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module uswl_ctrl_monitor (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire uswl_pkg::uswl_host_s       host,
  input wire uswl_pkg::uswl_traffic_s    traffic,
  input wire uswl_pkg::uswl_link_state_e link_state,
  input wire logic                       link_l1,
  input wire logic                       req_u0,
  input wire logic                       req_u2,
  input wire logic                       req_l0,
  input wire logic                       func_wake_notify,
  input wire logic                       hs_resume,
  input wire logic                       ltm_send,
  input wire logic                       lpm_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_l1_frame;
    lpm_enable && link_l1 && traffic.eth_frame_pass;
  endsequence
  sequence s_quiet;
    !ltm_send && !func_wake_notify && !hs_resume && !req_u0 && !req_u2;
  endsequence
  a_quiet_after_reset: assert property ($rose(aresetn) |-> s_quiet)
    else $error("output active right after reset");
  a_ltm_feature_gate: assert property (ltm_send |-> $past(host.ltm_feature))
    else $error("latency message without host enable");
  a_ltm_single_pulse: assert property (ltm_send |=> !ltm_send)
    else $error("latency message longer than one cycle");
  a_notify_in_u0: assert property (func_wake_notify |->
    $past(link_state) == uswl_pkg::USWL_LNK_U0 && $past(host.super_speed))
    else $error("wake notification outside U0");
  a_notify_one_cycle: assert property (func_wake_notify |=> !func_wake_notify)
    else $error("wake notification longer than one cycle");
  a_resume_gate: assert property (hs_resume |->
    $past(host.dev_rwake_en) && !$past(host.super_speed))
    else $error("resume without host enable or at superspeed");
  a_l1_exit: assert property (s_l1_frame |-> ##[1:2] req_l0)
    else $error("filtered frame in L1 did not request L0");
  a_u2_self_entry: assert property ($rose(req_u2) |->
    $past(host.func_suspend) && $past(host.u2_timeout) == uswl_pkg::U2_TIMEOUT_SELF)
    else $error("U2 request without suspend and timeout ff");
endmodule : uswl_ctrl_monitor
bind uswl_ctrl uswl_ctrl_monitor mon (.*);
`default_nettype wire

// *** tb/tb_uswl_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_uswl_ctrl;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  uswl_pkg::uswl_host_s host, hs;
  uswl_pkg::uswl_traffic_s traffic;
  uswl_pkg::uswl_link_state_e link_state, go_state;
  uswl_pkg::uswl_eth_speed_e eth_speed;
  uswl_pkg::uswl_power_s power;
  logic link_l1, link_l2, req_u0, req_u2, req_l0, func_wake_notify, hs_resume, ltm_send;
  logic lpm_enable, go, go_l1, arm, ack, rwake, hacc;
  logic [11:0] ltm_belt;
  int error_cnt, check_count;
  always_comb begin
    host = hs;
    host.func_rwake_en = rwake;
    host.host_access = hacc;
  end
  uswl_ctrl #(.U2_IDLE_CYC(50), .WAKE_RETRY_CYC(200)) dut (.*);
  uswl_host_model #(.DLY(3)) partner (.aclk(aclk), .aresetn(aresetn), .req_u0(req_u0),
    .req_u2(req_u2), .req_l0(req_l0), .go(go), .go_state(go_state), .go_l1(go_l1), .arm(arm),
    .ack(ack), .link_state(link_state), .link_l1(link_l1), .func_rwake_en(rwake),
    .host_access(hacc));
  task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axi(input bit we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    if (we) begin
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
    end
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!(we ? s_axi_bvalid : s_axi_rvalid) && n < 50);
    q = s_axi_rdata;
    r = we ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    if (n >= 50) error_cnt++;
  endtask : axi
  function automatic logic pick(input int s);
    case (s)
      0: return ltm_send;
      1: return req_u0;
      2: return func_wake_notify;
      3: return hs_resume;
      4: return req_l0;
      default: return req_u2;
    endcase
  endfunction : pick
  // ends on the first edge where the chosen output is seen, or at the limit
  task automatic wt(input int s, input int lim, output int c);
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (!pick(s) && c < lim);
  endtask : wt
  task automatic pulse(input int b);
    @(posedge aclk) traffic[b] <= 1'h1;
    @(posedge aclk) traffic[b] <= 1'h0;
  endtask : pulse
  task automatic link_go(input uswl_pkg::uswl_link_state_e st, input logic l1);
    @(posedge aclk);
    go <= 1'h1; go_state <= st; go_l1 <= l1;
    @(posedge aclk) go <= 1'h0;
  endtask : link_go
  task automatic reg_check();
    axi(0, uswl_pkg::OFF_USB_CFG_A, 32'h0); chk("cfg_a_rst", q, uswl_pkg::RST_USB_CFG_A);
    axi(0, 8'h28, 32'h0); chk("rd_unmapped", 32'(r), 32'h2);
    axi(1, 8'h30, 32'h1); chk("wr_unmapped", 32'(r), 32'h2);
    axi(0, uswl_pkg::OFF_USB_CFG_B, 32'h0); chk("cfg_b", q, 32'h1);
  endtask : reg_check
  task automatic ltm_cycle(input uswl_pkg::uswl_eth_speed_e sp, input logic [11:0] ea, ei);
    int c;
    @(posedge aclk);
    eth_speed <= sp; traffic.eth_rx_empty <= 1'h0;
    wt(0, 20, c); chk("belt_act", 32'(ltm_belt), 32'(ea));
    @(posedge aclk) traffic.eth_rx_empty <= 1'h1;
    wt(0, 40, c); chk("belt_idle", 32'(ltm_belt), 32'(ei));
    chk("inact_wait", 32'(c >= 5), 32'h1);
  endtask : ltm_cycle
  task automatic ltm_abort();
    int c;
    link_go(uswl_pkg::USWL_LNK_U1, 1'h0);
    hs.super_speed <= 1'h1;
    pulse(2); wt(1, 20, c); chk("frame_u0", 32'(pick(1)), 32'h1);
    wt(0, 20, c);
    @(posedge aclk) traffic.eth_rx_empty <= 1'h0;
    wt(0, 20, c); chk("abort_act", 32'(pick(0)), 32'h1);
    @(posedge aclk) traffic.eth_rx_empty <= 1'h1;
    repeat (2) @(posedge aclk);
    traffic.eth_rx_empty <= 1'h0;
    wt(0, 20, c); chk("abort_quiet", 32'(pick(0)), 32'h0);
    @(posedge aclk) traffic.eth_rx_empty <= 1'h1;
    wt(0, 30, c); chk("abort_idle", 32'(ltm_belt), 32'h33);
  endtask : ltm_abort
  task automatic ltm_quiet(input logic feat, input uswl_pkg::uswl_eth_speed_e sp);
    int c;
    @(posedge aclk);
    hs.ltm_feature <= feat; eth_speed <= sp; traffic.eth_rx_empty <= 1'h0;
    wt(0, 20, c); chk("ltm_quiet", 32'(pick(0)), 32'h0);
    @(posedge aclk);
    traffic.eth_rx_empty <= 1'h1; hs.ltm_feature <= 1'h1; eth_speed <= uswl_pkg::USWL_SPD_GIG;
    wt(0, 30, c);
  endtask : ltm_quiet
  task automatic wake_ss();
    int c;
    @(posedge aclk);
    hs.super_speed <= 1'h1; hs.func_suspend <= 1'h1; arm <= 1'h1;
    @(posedge aclk) arm <= 1'h0;
    link_go(uswl_pkg::USWL_LNK_U3, 1'h0);
    pulse(0); wt(1, 20, c); chk("wake_u0", 32'(pick(1)), 32'h1);
    wt(2, 30, c); chk("wake_note", 32'(pick(2)), 32'h1);
    wt(2, 400, c); chk("wake_retry", 32'(pick(2)), 32'h1);
    chk("retry_gap", 32'(c >= 195), 32'h1);
    @(posedge aclk) ack <= 1'h1;
    @(posedge aclk) ack <= 1'h0;
    wt(2, 300, c); chk("no_retry", 32'(pick(2)), 32'h0);
    link_go(uswl_pkg::USWL_LNK_U3, 1'h0);
    pulse(0); wt(1, 20, c); chk("wake_gate", 32'(pick(1)), 32'h0);
    @(posedge aclk) hs.u2_timeout <= 8'hff;
    link_go(uswl_pkg::USWL_LNK_U1, 1'h0);
    wt(5, 100, c); chk("u2_self", 32'(pick(5)), 32'h1);
    chk("u2_wait", 32'(c >= 50), 32'h1);
  endtask : wake_ss
  task automatic power_lpm();
    int c;
    axi(1, uswl_pkg::OFF_PM_CTL, 32'h2);
    link_go(uswl_pkg::USWL_LNK_U2, 1'h0);
    repeat (2) @(posedge aclk);
    chk("pwr_ux", 32'(power), 32'h5);
    hs <= '0;
    link_go(uswl_pkg::USWL_LNK_U0, 1'h0);
    link_l2 <= 1'h1;
    repeat (2) @(posedge aclk);
    chk("pwr_l2", 32'(power), 32'h5);
    link_l2 <= 1'h0; hs.dev_rwake_en <= 1'h1;
    pulse(0); wt(3, 20, c); chk("hs_wake", 32'(pick(3)), 32'h1);
    link_go(uswl_pkg::USWL_LNK_U0, 1'h1);
    pulse(1); wt(4, 10, c); chk("l1_exit", 32'(pick(4)), 32'h1);
    chk("lpm_on", 32'(lpm_enable), 32'h1);
    @(posedge aclk) hs.super_speed <= 1'h1;
    pulse(0); wt(3, 20, c); chk("ss_no_resume", 32'(pick(3)), 32'h0);
    @(posedge aclk) hs.super_speed <= 1'h0;
    axi(1, uswl_pkg::OFF_USB_CFG_A, 32'h0);
    pulse(0); wt(3, 20, c); chk("no_support", 32'(pick(3)), 32'h0);
    chk("lpm_off", 32'(lpm_enable), 32'h0);
  endtask : power_lpm
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    logic [7:0] ra [7] = '{8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
    logic [31:0] rv [7] = '{32'h1, 32'h0022_0011, 32'h33, 32'h00b2_00a1, 32'hc3,
                            32'h0005_0005, 32'h5};
    aresetn = 1'h0; hs = '0; traffic = 8'hf0; eth_speed = uswl_pkg::USWL_SPD_GIG;
    link_l2 = 1'h0; go = 1'h0; go_state = uswl_pkg::USWL_LNK_U0; go_l1 = 1'h0;
    arm = 1'h0; ack = 1'h0; s_axi_wstrb = 4'hf; s_axi_awvalid = 1'h0; s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0; s_axi_arvalid = 1'h0; s_axi_rready = 1'h0;
    s_axi_awaddr = 8'h0; s_axi_araddr = 8'h0; s_axi_wdata = 32'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 7; i++) axi(1, ra[i], rv[i]);
    reg_check();
    @(posedge aclk) hs.ltm_feature <= 1'h1;
    ltm_cycle(uswl_pkg::USWL_SPD_GIG, 12'h0a1, 12'h011);
    ltm_cycle(uswl_pkg::USWL_SPD_FAST, 12'h0b2, 12'h022);
    ltm_cycle(uswl_pkg::USWL_SPD_SLOW, 12'h0c3, 12'h033);
    ltm_abort();
    ltm_quiet(1'h0, uswl_pkg::USWL_SPD_GIG);
    ltm_quiet(1'h1, uswl_pkg::USWL_SPD_NONE);
    wake_ss();
    power_lpm();
    report_and_stop();
  end
endmodule : tb_uswl_ctrl
`default_nettype wire
